// ===== rtl/dch_access_pkg.sv
// Constants shared by the signalling-channel access controller.
// Assumes a 32-bit APB master and a 96-bit terminal bus frame, one bit per link clock.
package dch_access_pkg;
  // APB register byte addresses
  localparam logic [7:0] MODE_ADDR = 8'h00;
  localparam logic [7:0] BUSCTL_ADDR = 8'h04;
  localparam logic [7:0] CMDOUT_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [3:0] CMD_CODE_RST = 4'hF;
  localparam logic [2:0] ARB_ADDR_RST = 3'h7;
  // Field positions in the command-out register
  localparam int CMD_CODE_LSB = 0;
  localparam int BUS_TAKEN_POS = 4;
  localparam int ARB_ADDR_LSB = 5;
  localparam int CLASS_POS = 8;
  // Disable bit of the terminal bus control register
  localparam int BUSCTL_DIS_POS = 4;
  // Frame layout
  localparam logic [6:0] FRAME_LAST_BIT = 7'h5F;
  localparam logic [3:0] CI0_OCTET = 4'h3;
  localparam logic [3:0] ARB_OCTET = 4'hB;
  localparam logic [2:0] CI_MSB_POS = 3'h5;
  localparam logic [2:0] CI_LSB_POS = 3'h2;
  localparam logic [2:0] BAC_POS = 3'h5;
  localparam logic [2:0] ARB_MSB_POS = 3'h4;
  localparam logic [2:0] ARB_LSB_POS = 3'h2;
  localparam logic [2:0] DEFAULT_ADDR = 3'h7;
  // Bus-free frames needed after an access, minus one
  localparam logic [1:0] FREE_FRAMES_LAST = 2'h1;
  // Echo runs of ones before transmission
  localparam logic [3:0] RUN_CLASS1 = 4'h8;
  localparam logic [3:0] RUN_CLASS2 = 4'hA;
  localparam logic [3:0] RUN_MAX = 4'hF;
  // Terminal bus arbitration states
  typedef enum logic [1:0] {
    TIC_IDLE = 2'b00,
    TIC_ADDR = 2'b01,
    TIC_OWN = 2'b11,
    TIC_BACKOFF = 2'b10
  } tic_state_t;
  // Echo access states
  typedef enum logic {
    S_MON = 1'b0,
    S_SEND = 1'b1
  } s_state_t;
endpackage

// ===== rtl/dch_access.sv
// Signalling-channel access controller: terminal bus arbitration and echo-bit priority.
// Assumes link clock, frame sync and upstream line are asynchronous pins; HDLC and
// transceiver strobes come from logic on I_CLK.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module dch_access (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Terminal bus pins
  input wire logic I_LINK_CLK,
  input wire logic I_FRAME_SYNC,
  input wire logic I_UPSTREAM,
  output logic O_UPSTREAM,
  output logic O_UPSTREAM_OE,
  output logic O_DOWNSTREAM,
  // HDLC side
  input wire logic I_HDLC_PENDING,
  input wire logic I_SIG_FRAME,
  input wire logic I_D_TX_BIT,
  input wire logic I_FRAME_DONE,
  output logic O_D_GRANT,
  // Transceiver side
  input wire logic I_S_ACTIVE,
  input wire logic I_ECHO_VALID,
  input wire logic I_ECHO_BIT,
  output logic O_S_D_BIT
);
  import dch_access_pkg::*;

  logic [2:0] mode_reg;
  logic busctl_dis_reg;
  logic [3:0] cmd_code_reg;
  logic bus_taken_reg;
  logic [2:0] arb_addr_reg;
  logic class1_reg;
  logic collision_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic lclk_s1, lclk_s2, lclk_s3;
  logic fsync_s1, fsync_s2, fsync_s3;
  logic up_s1, up_s2;
  logic [6:0] bit_cnt_reg;
  logic [6:0] bit_cnt_next;
  logic du_low_reg;
  logic du_low_next;
  tic_state_t tic_state_reg;
  logic [1:0] free_cnt_reg;
  logic seen7_reg;
  logic default_acc_reg;
  s_state_t s_state_reg;
  logic [3:0] echo_cnt_reg;
  logic low_level_reg;
  logic sent_bit_reg;
  logic lclk_rise, lclk_fall, fsync_rise;
  logic tic_en, echo_en, tic_req;
  logic [3:0] cur_octet;
  logic [2:0] cur_pos;
  logic in_arb_octet;
  logic addr_lose;
  logic use_class1;
  logic [3:0] need;
  logic collide;
  logic stop_go;
  logic wr_en, setup;

  // Octet index and bit position (MSB sent first) of a frame bit
  function automatic logic [3:0] octet_of(input logic [6:0] b);
    octet_of = b[6:3];
  endfunction
  function automatic logic [2:0] pos_of(input logic [6:0] b);
    pos_of = 3'h7 - b[2:0];
  endfunction

  // Mode decode; the extra control bit lets software park arbitration
  assign tic_en = (mode_reg[2:1] == 2'b00) && !busctl_dis_reg;
  assign echo_en = (mode_reg[2] == 1'b0) && mode_reg[0];
  assign tic_req = bus_taken_reg | I_HDLC_PENDING;

  // APB: zero wait states, read data and error captured in the setup cycle
  assign setup = I_PSEL && !I_PENABLE;
  assign wr_en = I_PSEL && I_PENABLE && I_PWRITE;
  assign O_PREADY = 1'b1;
  assign O_PRDATA = prdata_reg;
  assign O_PSLVERR = slverr_reg && I_PSEL && I_PENABLE;

  // Software registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mode_reg <= MODE_RST;
      busctl_dis_reg <= 1'b0;
      cmd_code_reg <= CMD_CODE_RST;
      bus_taken_reg <= 1'b0;
      arb_addr_reg <= ARB_ADDR_RST;
      class1_reg <= 1'b0;
    end else if (wr_en) begin
      if (I_PADDR == MODE_ADDR) begin
        mode_reg <= I_PWDATA[2:0];
      end else if (I_PADDR == BUSCTL_ADDR) begin
        busctl_dis_reg <= I_PWDATA[BUSCTL_DIS_POS];
      end else if (I_PADDR == CMDOUT_ADDR) begin
        cmd_code_reg <= I_PWDATA[CMD_CODE_LSB +: 4];
        bus_taken_reg <= I_PWDATA[BUS_TAKEN_POS];
        arb_addr_reg <= I_PWDATA[ARB_ADDR_LSB +: 3];
        class1_reg <= I_PWDATA[CLASS_POS];
      end
    end
  end

  // Read mux, registered so data is steady for the whole access phase
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prdata_reg <= 32'h0;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      slverr_reg <= 1'b0;
      if (I_PADDR == MODE_ADDR) begin
        prdata_reg <= {29'h0, mode_reg};
      end else if (I_PADDR == BUSCTL_ADDR) begin
        prdata_reg <= {27'h0, busctl_dis_reg, 4'h0};
      end else if (I_PADDR == CMDOUT_ADDR) begin
        prdata_reg <= {23'h0, class1_reg, arb_addr_reg, bus_taken_reg, cmd_code_reg};
      end else if (I_PADDR == STATUS_ADDR) begin
        prdata_reg <= {21'h0, collision_reg, echo_cnt_reg, low_level_reg, s_state_reg == S_SEND,
                       stop_go, tic_state_reg == TIC_BACKOFF, O_D_GRANT, tic_state_reg == TIC_OWN};
      end else begin
        prdata_reg <= 32'h0;
        slverr_reg <= 1'b1;
      end
    end
  end

  // Pin synchronisers; only the second stage and later are read
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      {lclk_s1, lclk_s2, lclk_s3} <= 3'h0;
      {fsync_s1, fsync_s2, fsync_s3} <= 3'h0;
      {up_s1, up_s2} <= 2'h3;
    end else begin
      {lclk_s1, lclk_s2, lclk_s3} <= {I_LINK_CLK, lclk_s1, lclk_s2};
      {fsync_s1, fsync_s2, fsync_s3} <= {I_FRAME_SYNC, fsync_s1, fsync_s2};
      {up_s1, up_s2} <= {I_UPSTREAM, up_s1};
    end
  end
  assign lclk_rise = lclk_s2 && !lclk_s3;
  assign lclk_fall = !lclk_s2 && lclk_s3;
  assign fsync_rise = fsync_s2 && !fsync_s3;

  // Bit position: advanced on each link clock rise, realigned only by a frame sync rise seen in that same cycle
  always_comb begin
    if (fsync_rise || bit_cnt_reg == FRAME_LAST_BIT) begin
      bit_cnt_next = 7'h0;
    end else begin
      bit_cnt_next = bit_cnt_reg + 7'h1;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      bit_cnt_reg <= 7'h0;
    end else if (lclk_rise) begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end
  assign cur_octet = octet_of(bit_cnt_reg);
  assign cur_pos = pos_of(bit_cnt_reg);
  assign in_arb_octet = cur_octet == ARB_OCTET;

  // Upstream drive: open drain, we only ever pull low, so a zero wins
  always_comb begin
    du_low_next = 1'b0;
    if (octet_of(bit_cnt_next) == CI0_OCTET && pos_of(bit_cnt_next) <= CI_MSB_POS &&
        pos_of(bit_cnt_next) >= CI_LSB_POS) begin
      du_low_next = !cmd_code_reg[2'(pos_of(bit_cnt_next) - CI_LSB_POS)];
    end else if (octet_of(bit_cnt_next) == ARB_OCTET) begin
      if (pos_of(bit_cnt_next) == BAC_POS) begin
        du_low_next = tic_state_reg == TIC_OWN;
      end else if (tic_state_reg == TIC_ADDR && pos_of(bit_cnt_next) <= ARB_MSB_POS &&
                   pos_of(bit_cnt_next) >= ARB_LSB_POS) begin
        du_low_next = !arb_addr_reg[2'(pos_of(bit_cnt_next) - ARB_LSB_POS)];
      end
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      du_low_reg <= 1'b0;
    end else if (lclk_rise) begin
      du_low_reg <= du_low_next;
    end
  end
  assign O_UPSTREAM = 1'b0;
  assign O_UPSTREAM_OE = du_low_reg;

  // A driven one read back as zero means a lower address is on the line
  assign addr_lose = tic_state_reg == TIC_ADDR && lclk_fall && in_arb_octet &&
                     cur_pos <= ARB_MSB_POS && cur_pos >= ARB_LSB_POS &&
                     arb_addr_reg[2'(cur_pos - ARB_LSB_POS)] && !up_s2;

  // Arbitration, sampled on the link clock fall in the middle of each bit
  always_ff @(posedge I_CLK) begin
    if (I_RST || !tic_en) begin
      tic_state_reg <= TIC_IDLE;
      free_cnt_reg <= 2'h0;
    end else if (lclk_fall && in_arb_octet) begin
      case (tic_state_reg)
        TIC_IDLE: begin
          if (cur_pos == BAC_POS && tic_req && up_s2) begin
            tic_state_reg <= TIC_ADDR;
          end
        end
        TIC_ADDR: begin
          if (addr_lose) begin
            tic_state_reg <= TIC_IDLE;
          end else if (cur_pos == ARB_LSB_POS) begin
            tic_state_reg <= TIC_OWN;
          end
        end
        TIC_OWN: begin
          if (cur_pos == BAC_POS && !tic_req) begin
            tic_state_reg <= TIC_BACKOFF;
            free_cnt_reg <= 2'h0;
          end
        end
        TIC_BACKOFF: begin
          if (cur_pos == BAC_POS) begin
            if (!up_s2) begin
              free_cnt_reg <= 2'h0;
            end else if (free_cnt_reg == FREE_FRAMES_LAST) begin
              tic_state_reg <= TIC_IDLE;
            end else begin
              free_cnt_reg <= free_cnt_reg + 2'h1;
            end
          end
        end
        default: tic_state_reg <= TIC_IDLE;
      endcase
    end
  end

  // Default access: an idle line shows bus free and address 7
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      seen7_reg <= 1'b0;
      default_acc_reg <= 1'b0;
    end else if (lclk_fall && in_arb_octet) begin
      if (cur_pos == BAC_POS) begin
        seen7_reg <= up_s2;
      end else if (cur_pos <= ARB_MSB_POS && cur_pos >= ARB_LSB_POS) begin
        seen7_reg <= seen7_reg && up_s2;
      end
      if (cur_pos == ARB_LSB_POS) begin
        default_acc_reg <= seen7_reg && up_s2 && arb_addr_reg == DEFAULT_ADDR;
      end
    end
  end
  assign O_D_GRANT = !tic_en || tic_state_reg == TIC_OWN || default_acc_reg;

  // Echo priority; signalling frames always take class 1
  assign use_class1 = I_SIG_FRAME || class1_reg;
  assign need = (use_class1 ? RUN_CLASS1 : RUN_CLASS2) + {3'h0, low_level_reg};
  assign collide = s_state_reg == S_SEND && I_ECHO_VALID && I_ECHO_BIT != sent_bit_reg;

  // Run-of-ones counter, saturating so long idle does not wrap into a false short run
  always_ff @(posedge I_CLK) begin
    if (I_RST || !echo_en || !I_S_ACTIVE) begin
      echo_cnt_reg <= 4'h0;
    end else if (I_ECHO_VALID) begin
      if (!I_ECHO_BIT) begin
        echo_cnt_reg <= 4'h0;
      end else if (echo_cnt_reg != RUN_MAX) begin
        echo_cnt_reg <= echo_cnt_reg + 4'h1;
      end
    end
  end

  // Send / monitor machine
  always_ff @(posedge I_CLK) begin
    if (I_RST || !echo_en || !I_S_ACTIVE) begin
      s_state_reg <= S_MON;
      sent_bit_reg <= 1'b1;
    end else begin
      case (s_state_reg)
        S_MON: begin
          sent_bit_reg <= 1'b1;
          if (I_HDLC_PENDING && echo_cnt_reg >= need) begin
            s_state_reg <= S_SEND;
          end
        end
        S_SEND: begin
          if (collide || I_FRAME_DONE) begin
            s_state_reg <= S_MON;
            sent_bit_reg <= 1'b1;
          end else if (I_ECHO_VALID) begin
            sent_bit_reg <= I_D_TX_BIT;
          end
        end
        default: s_state_reg <= S_MON;
      endcase
    end
  end
  assign O_S_D_BIT = sent_bit_reg;

  // Lowered level after a good frame, restored once a full lowered run was seen
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      low_level_reg <= 1'b0;
    end else if (s_state_reg == S_SEND && I_FRAME_DONE && !collide) begin
      low_level_reg <= 1'b1;
    end else if (s_state_reg == S_MON && echo_cnt_reg >= need) begin
      low_level_reg <= 1'b0;
    end
  end

  // Collision flag: set wins over the clear caused by reading status
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      collision_reg <= 1'b0;
    end else if (collide) begin
      collision_reg <= 1'b1;
    end else if (I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == STATUS_ADDR) begin
      collision_reg <= 1'b0;
    end
  end

  // Downstream: only the stop/go bit carries information, the rest idles high
  assign stop_go = echo_en && s_state_reg != S_SEND && echo_cnt_reg < need;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_DOWNSTREAM <= 1'b1;
    end else if (lclk_rise) begin
      O_DOWNSTREAM <= (octet_of(bit_cnt_next) == ARB_OCTET && pos_of(bit_cnt_next) == BAC_POS) ?
                      stop_go : 1'b1;
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence s_arb_start;
    tic_state_reg == TIC_IDLE ##1 tic_state_reg == TIC_ADDR;
  endsequence
  sequence s_backoff_done;
    tic_state_reg == TIC_BACKOFF ##1 tic_state_reg == TIC_IDLE;
  endsequence
  sequence s_tx_start;
    s_state_reg == S_MON ##1 s_state_reg == S_SEND;
  endsequence

  property p_tic_off;
    !tic_en |=> tic_state_reg == TIC_IDLE;
  endproperty
  a_tic_off: assert property (p_tic_off) else $error("arbitration active while disabled");
  property p_drive_window;
    du_low_reg |-> (cur_octet == CI0_OCTET || cur_octet == ARB_OCTET);
  endproperty
  a_drive_window: assert property (p_drive_window) else $error("upstream driven outside its octets");
  property p_req_cause;
    s_arb_start |-> $past(tic_req);
  endproperty
  a_req_cause: assert property (p_req_cause) else $error("arbitration without request");
  property p_free_seen;
    s_arb_start |-> $past(up_s2) && $past(cur_pos) == BAC_POS;
  endproperty
  a_free_seen: assert property (p_free_seen) else $error("arbitration started on busy bus");
  property p_withdraw;
    addr_lose |=> tic_state_reg == TIC_IDLE ##1 !du_low_reg || !in_arb_octet;
  endproperty
  a_withdraw: assert property (p_withdraw) else $error("lost arbitration not withdrawn");
  property p_two_free;
    s_backoff_done |-> $past(free_cnt_reg) == FREE_FRAMES_LAST;
  endproperty
  a_two_free: assert property (p_two_free) else $error("back-off ended early");
  property p_run_reset;
    echo_en && I_S_ACTIVE && I_ECHO_VALID && !I_ECHO_BIT |=> echo_cnt_reg == 4'h0;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("echo run not restarted");
  property p_run_needed;
    s_tx_start |-> $past(echo_cnt_reg) >= $past(need);
  endproperty
  a_run_needed: assert property (p_run_needed) else $error("sent before required run");
  property p_collision;
    collide |=> s_state_reg == S_MON && O_S_D_BIT;
  endproperty
  a_collision: assert property (p_collision) else $error("collision did not stop sending");
  property p_idle_ones;
    s_state_reg == S_MON [*2] |-> O_S_D_BIT;
  endproperty
  a_idle_ones: assert property (p_idle_ones) else $error("zero sent while idle");
endmodule

// ===== tb/tic_peer.sv
// Far side of the terminal bus: bit clock, frame sync and one peer controller.
// Assumes a pull-up on the upstream wire; the peer only ever pulls it low.
`timescale 1ns/10ps
module tic_peer (
  // Wire and request
  input wire logic i_wire,
  input wire logic i_req,
  input wire logic [2:0] i_addr,
  // Timing and drive
  output logic o_link_clk,
  output logic o_frame_sync,
  output logic o_pull_low,
  output logic o_owns,
  output logic [6:0] o_bit
);
  logic arb_reg;
  // Bit clock runs free while the bus is up
  initial begin
    o_link_clk = 1'b0;
    o_frame_sync = 1'b0;
    o_owns = 1'b0;
    o_bit = 7'h5F;
    arb_reg = 1'b0;
  end
  always #100 o_link_clk = ~o_link_clk;
  // Bit counter moves on the rising edge, 96 bits a frame
  always @(posedge o_link_clk) begin
    o_bit <= (o_bit == 7'h5F) ? 7'h00 : o_bit + 7'h01;
  end
  // Drive only in the last channel-2 octet; released bits float high, so idle shows address 7
  always @* begin
    o_pull_low = 1'b0;
    if (o_bit == 7'h5A) begin
      o_pull_low = o_owns;
    end else if (o_bit >= 7'h5B && o_bit <= 7'h5D) begin
      o_pull_low = arb_reg && !i_addr[7'h5D - o_bit];
    end
  end
  // Sample on the falling edge; sync rises mid bit 95 so the next bit is bit 0
  always @(negedge o_link_clk) begin
    o_frame_sync <= (o_bit == 7'h5F);
    if (o_bit == 7'h5A) begin
      arb_reg <= i_req && !o_owns && i_wire;
    end
    if (o_bit >= 7'h5B && o_bit <= 7'h5D && i_addr[7'h5D - o_bit] && !i_wire) begin
      arb_reg <= 1'b0;
    end
    if (o_bit == 7'h5D) begin
      o_owns <= i_req && (o_owns || (arb_reg && !(i_addr[0] && !i_wire)));
    end
  end
endmodule

// ===== tb/d_channel_access_control_tb_top.sv
// Self-checking bench for the signalling-channel access controller.
// Assumes the peer model supplies bus timing; APB and echo strobes come from here.
`timescale 1ns/10ps
module d_channel_access_control_tb_top;
  import dch_access_pkg::*;
  localparam logic [2:0] DEV_TAB [3] = '{3'h3, 3'h6, 3'h0};
  localparam logic [2:0] PEER_TAB [3] = '{3'h5, 3'h1, 3'h7};
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er, win;
  logic hdlc_pending, sig_frame, d_tx_bit, frame_done, s_active, echo_valid, echo_bit;
  logic up_out, up_oe, down, grant, s_d_bit, link_clk, fsync, peer_req, peer_pull, peer_owns, wire_lvl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] peer_addr;
  logic [3:0] code;
  logic [6:0] bit_idx;
  int fails, checks_done, lowered;
  // Wired-AND with pull-up: any party pulling low wins
  assign wire_lvl = (up_oe ? up_out : 1'b1) & ~peer_pull;
  dch_access dch_access_inst (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_LINK_CLK(link_clk), .I_FRAME_SYNC(fsync), .I_UPSTREAM(wire_lvl),
    .O_UPSTREAM(up_out), .O_UPSTREAM_OE(up_oe), .O_DOWNSTREAM(down), .I_HDLC_PENDING(hdlc_pending),
    .I_SIG_FRAME(sig_frame), .I_D_TX_BIT(d_tx_bit), .I_FRAME_DONE(frame_done), .O_D_GRANT(grant),
    .I_S_ACTIVE(s_active), .I_ECHO_VALID(echo_valid), .I_ECHO_BIT(echo_bit), .O_S_D_BIT(s_d_bit));
  tic_peer tic_peer_inst (.i_wire(wire_lvl), .i_req(peer_req), .i_addr(peer_addr), .o_link_clk(link_clk),
    .o_frame_sync(fsync), .o_pull_low(peer_pull), .o_owns(peer_owns), .o_bit(bit_idx));
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  task automatic finish_test();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // A wait that runs out counts as a mismatch and ends the run
  task automatic hang();
    chk_bit(1'b0, 1'b1);
    finish_test();
  endtask
  // One APB transfer; the slave's pready decides when it completes
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_bit(input logic [6:0] b);
    int n;
    n = 0;
    do begin
      @(posedge link_clk);
      #1;
      n++;
    end while (bit_idx !== b && n < 200);
    if (n >= 200) hang();
  endtask
  task automatic wait_frames(input int f);
    repeat (f) wait_bit(7'h00);
  endtask
  // Wire is judged mid-bit, well after the device's synced drive has landed
  task automatic wire_at(input logic [6:0] b, input logic exp);
    wait_bit(b);
    @(negedge link_clk);
    chk_bit(wire_lvl, exp);
  endtask
  task automatic echo(input logic b);
    @(posedge clk);
    echo_valid <= 1'b1;
    echo_bit <= b;
    @(posedge clk);
    echo_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Count echo ones until our zero goes out; expected run from class and level
  task automatic echo_run(input logic cls1, input logic collide);
    int n, need;
    need = (cls1 ? 8 : 10) + lowered;
    n = 0;
    // Zero first, so a long run left from the last frame cannot start a send early
    echo(1'b0);
    @(posedge clk);
    hdlc_pending <= 1'b1;
    sig_frame <= cls1;
    d_tx_bit <= 1'b0;
    do begin
      echo(1'b1);
      n++;
    end while (s_d_bit === 1'b1 && n < 20);
    chk_word(32'(n), 32'(need + 1));
    if (collide) begin
      // Drop the request so the full run left after the collision does not resend
      @(posedge clk);
      hdlc_pending <= 1'b0;
      echo(1'b1);
      chk_bit(s_d_bit, 1'b1);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk_bit(rd[10], 1'b1);
    end else begin
      echo(1'b0);
      chk_bit(s_d_bit, 1'b0);
      @(posedge clk);
      frame_done <= 1'b1;
      @(posedge clk);
      frame_done <= 1'b0;
      lowered = 1;
    end
    @(posedge clk);
    hdlc_pending <= 1'b0;
    echo(1'b1);
    chk_bit(s_d_bit, 1'b1);
  endtask
  // Main sequence
  initial begin
    {clk, psel, penable, pwrite, hdlc_pending, sig_frame, d_tx_bit, frame_done} = 8'h00;
    {s_active, echo_valid, echo_bit, peer_req, paddr, pwdata} = '0;
    peer_addr = 3'h7;
    rst = 1'b1;
    fails = 0;
    checks_done = 0;
    lowered = 0;
    void'($urandom(32'h89A2DA5B));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CMDOUT_ADDR, 32'h0);
    chk_word(rd, 32'h000000EF);
    apb(1'b0, MODE_ADDR, 32'h0);
    chk_word(rd, 32'h00000000);
    apb(1'b0, 8'h10, 32'h0);
    chk_bit(er, 1'b1);
    chk_word(rd, 32'h00000000);
    // Idle bus shows address 7; only the owner of 7 gets default access
    wait_frames(2);
    chk_bit(grant, 1'b1);
    apb(1'b1, CMDOUT_ADDR, 32'h0000006F);
    wait_frames(2);
    chk_bit(grant, 1'b0);
    // Arbitration off: command code goes out inverted-free on the wire, MSB first
    code = 4'($urandom());
    apb(1'b1, MODE_ADDR, 32'h00000002);
    apb(1'b1, BUSCTL_ADDR, 32'h00000010);
    apb(1'b1, CMDOUT_ADDR, {24'h0, 3'h7, 1'b0, code});
    @(posedge clk);
    #1;
    chk_bit(grant, 1'b1);
    wait_frames(1);
    for (int k = 0; k < 4; k++) begin
      wire_at(7'(7'h1A + k), code[3 - k]);
    end
    // Echo priority on the S side
    apb(1'b1, MODE_ADDR, 32'h00000003);
    @(posedge clk);
    s_active <= 1'b1;
    echo_run(1'b1, 1'b1);
    echo_run(1'b1, 1'b0);
    echo_run(1'b1, 1'b0);
    repeat (12) echo(1'b1);
    lowered = 0;
    echo_run(1'b0, 1'b0);
    echo_run(1'b0, 1'b0);
    @(posedge clk);
    s_active <= 1'b0;
    // Class select chosen by the controller is held in the command-out word
    apb(1'b1, CMDOUT_ADDR, 32'h000001EF);
    apb(1'b0, CMDOUT_ADDR, 32'h0);
    chk_word(rd, 32'h000001EF);
    // Shared bus arbitration enabled again
    apb(1'b1, MODE_ADDR, 32'h00000000);
    apb(1'b1, BUSCTL_ADDR, 32'h00000000);
    @(posedge clk);
    hdlc_pending <= 1'b1;
    wait_frames(2);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk_bit(rd[0], 1'b1);
    @(posedge clk);
    hdlc_pending <= 1'b0;
    wait_frames(3);
    for (int i = 0; i < 3; i++) begin
      wait_bit(7'h08);
      @(posedge clk);
      peer_addr <= PEER_TAB[i];
      peer_req <= 1'b1;
      apb(1'b1, CMDOUT_ADDR, {24'h0, DEV_TAB[i], 1'b1, 4'hF});
      wait_frames(2);
      win = DEV_TAB[i] < PEER_TAB[i];
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk_bit(rd[0], win);
      chk_bit(peer_owns, !win);
      wire_at(7'h5A, 1'b0);
      // Winner lets go; the loser must still be pending and take over
      if (win) begin
        apb(1'b1, CMDOUT_ADDR, {24'h0, DEV_TAB[i], 1'b0, 4'hF});
      end else begin
        @(posedge clk);
        peer_req <= 1'b0;
      end
      wait_frames(3);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk_bit(rd[0], !win);
      chk_bit(peer_owns, win);
      apb(1'b1, CMDOUT_ADDR, {24'h0, DEV_TAB[i], 1'b0, 4'hF});
      peer_req <= 1'b0;
      wait_frames(3);
    end
    // Back-off: a request right after an access waits two free frames
    apb(1'b1, CMDOUT_ADDR, 32'h0000005F);
    wait_frames(2);
    // The release must stand over one bus-taken sample, or the owner never lets go
    apb(1'b1, CMDOUT_ADDR, 32'h0000004F);
    wait_frames(1);
    apb(1'b1, CMDOUT_ADDR, 32'h0000005F);
    wait_frames(1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk_bit(rd[0], 1'b0);
    wait_frames(3);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk_bit(rd[0], 1'b1);
    finish_test();
  end
endmodule
